// >>> flash_erase_pkg.sv
// Types shared by the erase sequencer files.
`default_nettype none
package flash_erase_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ERASE  = 3'b010,
    ST_SETTLE = 3'b100
  } erase_state_t;

  typedef enum logic [1:0] {
    KIND_BLOCK  = 2'b01,
    KIND_SECTOR = 2'b10
  } erase_kind_t;

endpackage
`default_nettype wire

// >>> flash_erase_regs.svh
// Named constants for the block and sector erase sequencer.
`ifndef FLASH_ERASE_REGS_SVH
`define FLASH_ERASE_REGS_SVH

// Erase opcodes.
`define OPC_BLOCK_ERASE   8'h50
`define OPC_SECTOR_ERASE  8'h7C

// Frame layout: one opcode byte then three address bytes.
`define FRAME_BITS        6'h20
`define OPC_LSB           24
`define OPC_W             8
`define ADDR_W            24

// Page number position inside the 24 address bits for each page size.
`define PAGE_W            15
`define STD_PAGE_LSB      9
`define BIN_PAGE_LSB      8

// Fields of the 15-bit page number.
`define BLK_LSB           3
`define BLK_W             12
`define SUB_W             7
`define SEC_LSB           10
`define SEC_W             5

// Page spans of the erase units.
`define CNT_W             11
`define PAGES_PER_BLOCK   11'h008
`define PAGES_PER_SECTOR  11'h400
`define SUB0A_PAGES       11'h008
`define SUB0B_FIRST_PAGE  15'h0008
`define SUB0B_PAGES       11'h3F8
`define SUB0B_CODE        7'h01

// Value of every erased byte.
`define ERASED_BYTE       8'hFF

// Core clock period in nanoseconds.
`define CLK_PERIOD_NS     10

`endif

// >>> flash_erase_sequencer.sv
// Block and sector erase command decoder and self-timed erase engine.
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_regs.svh"
module flash_erase_sequencer #(
  parameter int BLOCK_ERASE_TIME_US  = 25000,
  parameter int SECTOR_ERASE_TIME_US = 1000000
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 sck_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 si_i,
  input  wire logic                 binary_page_i,
  input  wire logic                 verify_fail_i,
  output logic                      ready_o,
  output logic                      erase_program_error_flag_o,
  output logic                      erase_page_strobe_o,
  output logic [`PAGE_W-1:0]        erase_page_addr_o,
  output logic [7:0]                erase_data_o
);
  import flash_erase_pkg::*;

  // Longest erase times rounded down to whole core cycles.
  localparam logic [31:0] BLOCK_CYC  = 32'(BLOCK_ERASE_TIME_US * 1000 / `CLK_PERIOD_NS);
  localparam logic [31:0] SECTOR_CYC = 32'(SECTOR_ERASE_TIME_US * 1000 / `CLK_PERIOD_NS);

  // The four serial and page-size pins pass two flops before any logic looks at them; verify_fail_i is used directly.
  // Chip select is carried inverted so the flops reset to the deselected level.
  // A false chip select edge right after reset is therefore impossible.
  logic [3:0] pins_sync;
  sync_stages #(
    .WIDTH (4)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .async_i    ({binary_page_i, si_i, ~cs_n_i, sck_i}),
    .sync_o     (pins_sync)
  );

  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic bin_s;
  assign sck_s  = pins_sync[0];
  assign cs_n_s = ~pins_sync[1];
  assign si_s   = pins_sync[2];
  assign bin_s  = pins_sync[3];

  // Frame capture state.
  logic        sck_d;
  logic        cs_n_d;
  logic [5:0]  bit_count;
  logic [31:0] shreg;
  logic [5:0]  next_bit_count;
  logic [31:0] next_shreg;
  logic        sck_rise;
  logic        cs_fall;
  logic        cs_rise;

  assign sck_rise = sck_s & ~sck_d;
  assign cs_fall  = ~cs_n_s & cs_n_d;
  assign cs_rise  = cs_n_s & ~cs_n_d;

  // Shift on serial clock rising edges inside the frame.
  always_comb begin
    next_bit_count = bit_count;
    next_shreg     = shreg;
    if (cs_fall) begin
      next_bit_count = '0;
    end else if (!cs_n_s && sck_rise && bit_count != `FRAME_BITS) begin
      // Saturating at a full frame drops any trailing bits.
      next_shreg     = {shreg[30:0], si_s};
      next_bit_count = bit_count + 6'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sck_d     <= 1'b0;
      cs_n_d    <= 1'b1;
      bit_count <= '0;
      shreg     <= '0;
    end else begin
      sck_d     <= sck_s;
      cs_n_d    <= cs_n_s;
      bit_count <= next_bit_count;
      shreg     <= next_shreg;
    end
  end

  // Command decode from the captured frame.
  logic [`OPC_W-1:0]  opcode;
  logic [`ADDR_W-1:0] addr;
  logic [`PAGE_W-1:0] page;
  logic [`BLK_W-1:0]  blk_num;
  logic [`SEC_W-1:0]  sec_num;
  logic [`SUB_W-1:0]  sub_num;
  logic               frame_full;
  logic               start_block;
  logic               start_sector;

  assign opcode = shreg[`OPC_LSB +: `OPC_W];
  assign addr   = shreg[`ADDR_W-1:0];
  assign page    = bin_s ? addr[`BIN_PAGE_LSB +: `PAGE_W] : addr[`STD_PAGE_LSB +: `PAGE_W];
  assign blk_num = page[`BLK_LSB +: `BLK_W];
  assign sec_num = page[`SEC_LSB +: `SEC_W];
  assign sub_num = page[`BLK_LSB +: `SUB_W];
  assign frame_full   = (bit_count == `FRAME_BITS);
  assign start_block  = cs_rise && frame_full && ready_o && opcode == `OPC_BLOCK_ERASE;
  assign start_sector = cs_rise && frame_full && ready_o && opcode == `OPC_SECTOR_ERASE;

  // Erase engine state.
  erase_state_t      state;
  erase_state_t      next_state;
  logic [`PAGE_W-1:0] cur_page;
  logic [`PAGE_W-1:0] next_cur_page;
  logic [`CNT_W-1:0]  pages_left;
  logic [`CNT_W-1:0]  next_pages_left;
  logic [31:0]        timer;
  logic [31:0]        next_timer;
  logic               err_flag;
  logic               next_err_flag;

  // Walk the pages one per cycle, then hold busy until the erase time ends.
  always_comb begin
    next_state      = state;
    next_cur_page   = cur_page;
    next_pages_left = pages_left;
    next_timer      = (timer != 32'h0) ? timer - 32'h1 : timer;
    next_err_flag   = err_flag;
    case (state)
      ST_IDLE: begin
        if (start_block) begin
          next_cur_page   = {blk_num, 3'h0};
          next_pages_left = `PAGES_PER_BLOCK;
          next_timer      = BLOCK_CYC - 32'h1;
          next_err_flag   = 1'b0;
          next_state      = ST_ERASE;
        end else if (start_sector) begin
          next_timer    = SECTOR_CYC - 32'h1;
          next_err_flag = 1'b0;
          next_state    = ST_ERASE;
          if (sec_num != '0) begin
            next_cur_page   = {sec_num, 10'h000};
            next_pages_left = `PAGES_PER_SECTOR;
          end else if (sub_num == '0) begin
            next_cur_page   = '0;
            next_pages_left = `SUB0A_PAGES;
          end else begin
            next_cur_page   = `SUB0B_FIRST_PAGE;
            next_pages_left = `SUB0B_PAGES;
          end
        end
      end
      ST_ERASE: begin
        if (verify_fail_i) begin
          next_err_flag = 1'b1;
        end
        next_cur_page   = cur_page + 15'h0001;
        next_pages_left = pages_left - 11'h001;
        if (pages_left == 11'h001) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (timer == 32'h0) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state      <= ST_IDLE;
      cur_page   <= '0;
      pages_left <= '0;
      timer      <= '0;
      err_flag   <= 1'b0;
    end else begin
      state      <= next_state;
      cur_page   <= next_cur_page;
      pages_left <= next_pages_left;
      timer      <= next_timer;
      err_flag   <= next_err_flag;
    end
  end

  // Erased bytes are driven as all ones; held in a flop so the bus is glitch free.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      erase_data_o <= `ERASED_BYTE;
    end else begin
      erase_data_o <= `ERASED_BYTE;
    end
  end

  assign ready_o                    = (state == ST_IDLE);
  assign erase_program_error_flag_o = err_flag;
  assign erase_page_strobe_o        = (state == ST_ERASE);
  assign erase_page_addr_o          = cur_page;

  // Checks that guard the sequencer.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  busy_after_start_a: assert property ((start_block || start_sector) |=> !ready_o)
    else $error("Not busy after erase start.");
  block_base_a: assert property (start_block |=> cur_page == {$past(blk_num), 3'h0}
    && pages_left == `PAGES_PER_BLOCK) else $error("Wrong block base or span.");
  block_time_a: assert property (start_block |=> timer == BLOCK_CYC - 32'h1)
    else $error("Block erase timer loaded wrong.");
  sector_high_a: assert property (start_sector && sec_num != '0 |=>
    cur_page == {$past(sec_num), 10'h000} && pages_left == `PAGES_PER_SECTOR)
    else $error("Wrong sector base.");
  sector_0a_a: assert property (start_sector && sec_num == '0 && sub_num == '0 |=>
    cur_page == '0 && pages_left == `SUB0A_PAGES) else $error("Wrong sub-sector 0a.");
  sector_time_a: assert property (start_sector |=> timer == SECTOR_CYC - 32'h1)
    else $error("Sector erase timer loaded wrong.");
  error_set_a: assert property (erase_page_strobe_o && verify_fail_i |=>
    erase_program_error_flag_o [*2]) else $error("Error flag not raised.");
  fill_ones_a: assert property (erase_page_strobe_o |-> erase_data_o == `ERASED_BYTE)
    else $error("Erased byte not all ones.");
  count_restart_a: assert property (cs_fall |=> bit_count == '0)
    else $error("Bit counter not restarted.");
  short_frame_a: assert property (cs_rise && !frame_full && ready_o |=> ready_o)
    else $error("Short frame started an erase.");
  busy_hold_a: assert property (state == ST_SETTLE && timer != 32'h0 |=> !ready_o)
    else $error("Busy dropped before erase time.");
  opcode_gate_a: assert property ($fell(ready_o) |-> $past(frame_full) &&
    ($past(opcode) == `OPC_BLOCK_ERASE || $past(opcode) == `OPC_SECTOR_ERASE))
    else $error("Erase started without valid frame.");

  block_run_c: cover property (start_block ##1 !ready_o [*8]);
  sector_run_c: cover property (start_sector && sec_num != '0);
  sub0b_run_c: cover property (start_sector && sec_num == '0 && sub_num != '0);
  error_seen_c: cover property ($rose(erase_program_error_flag_o));

endmodule
`default_nettype wire

// >>> spi_host_model.sv
// Host side model that clocks erase frames into the sequencer.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  // Mode 0 idle: the serial clock stays low and still between frames.
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b1;
  end

  task automatic send(input logic [39:0] w, input int nb);
    int i;
    #3;
    cs_n_o = 1'b0;
    for (i = nb - 1; i >= 0; i--) begin
      si_o = w[i];
      #80 sck_o = 1'b1;
      #80 sck_o = 1'b0;
    end
    #80 cs_n_o = 1'b1;
    // A released data line shows the inverse, so a stale bit cannot pass.
    si_o = ~si_o;
    #400;
  endtask
endmodule
`default_nettype wire

// >>> sync_stages.sv
// Two-flop synchroniser for a group of pin levels.
`timescale 1ns/1ps
`default_nettype none
module sync_stages #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second, so metastability never reaches logic.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the block and sector erase sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_regs.svh"
module tb_top;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               bin = 1'b0;
  logic               vf  = 1'b0;
  logic               sck;
  logic               cs_n;
  logic               si;
  logic               ready;
  logic               flag;
  logic               stb;
  logic [`PAGE_W-1:0] pa;
  logic [7:0]         dat;
  logic [`PAGE_W-1:0] first;
  logic [`PAGE_W-1:0] last;
  int                 n = 0;
  int                 fail_count = 0;
  int                 compares = 0;

  typedef struct {
    logic [31:0]        w;
    logic               b;
    logic               f;
    logic [`PAGE_W-1:0] fp;
    int                 c;
  } row_t;

  // Rows: frame, page size, fail input, first page, page count.
  row_t rows [7] = '{
    '{32'h50005A00, 1'b0, 1'b0, 15'h0028, 8},
    '{32'h50FFFFFF, 1'b1, 1'b1, 15'h7FF8, 8},
    '{32'h7C000A00, 1'b0, 1'b0, 15'h0000, 8},
    '{32'h7C03FF00, 1'b1, 1'b1, 15'h0008, 1016},
    '{32'h7CFFFE00, 1'b0, 1'b0, 15'h7C00, 1024},
    '{32'h7C840000, 1'b1, 1'b0, 15'h0400, 1024},
    '{32'h81000200, 1'b0, 1'b0, 15'h0000, 0}
  };

  always #5 clk = ~clk;

  spi_host_model host (
    .sck_o  (sck),
    .cs_n_o (cs_n),
    .si_o   (si)
  );

  flash_erase_sequencer #(
    .BLOCK_ERASE_TIME_US  (11),
    .SECTOR_ERASE_TIME_US (11)
  ) dut (
    .core_clk_i                 (clk),
    .sys_rst_i                  (rst),
    .sck_i                      (sck),
    .cs_n_i                     (cs_n),
    .si_i                       (si),
    .binary_page_i              (bin),
    .verify_fail_i              (vf),
    .ready_o                    (ready),
    .erase_program_error_flag_o (flag),
    .erase_page_strobe_o        (stb),
    .erase_page_addr_o          (pa),
    .erase_data_o               (dat)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Each strobed page is counted and its data byte checked.
  always @(posedge clk) begin
    if (stb === 1'b1) begin
      if (n == 0) first = pa;
      last = pa;
      n++;
      chk(32'(dat), 32'h000000FF);
    end
  end

  // Bounded wait for the busy flag to clear.
  task automatic wait_ready();
    int k;
    for (k = 0; k < 1500 && ready !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (ready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
  endtask

  task automatic run(input logic [39:0] w, input int nb, input row_t r);
    n = 0;
    bin = r.b;
    vf = r.f;
    host.send(w, nb);
    repeat (6) @(posedge clk);
    #1;
    chk(32'(ready), 32'(r.c == 0));
    wait_ready();
    chk(n, r.c);
    if (r.c != 0) begin
      chk(32'(first), 32'(r.fp));
      chk(32'(last), 32'(r.fp) + r.c - 1);
    end
    chk(32'(flag), 32'(r.f));
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk(32'({ready, flag, stb, pa, dat}), 32'h020000FF);
    repeat (3) @(posedge clk);
    foreach (rows[i]) run(40'(rows[i].w), 32, rows[i]);
    // Bits past the frame are ignored; a short frame is refused.
    run({rows[0].w, 8'hA5} >> 7, 33, rows[0]);
    run(40'(rows[0].w >> 1), 31, rows[6]);
    // A frame sent while busy must be dropped.
    n = 0;
    host.send(40'(rows[2].w), 32);
    host.send(40'(rows[0].w), 32);
    wait_ready();
    repeat (10) @(posedge clk);
    #1;
    chk(n, 8);
    chk(32'(ready), 32'h1);
    // Reset in mid-erase returns to idle.
    bin = 1'b0;
    host.send(40'(rows[4].w), 32);
    repeat (20) @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk(32'({ready, flag, stb}), 32'h4);
    repeat (3) @(posedge clk);
    run(40'(rows[0].w), 32, rows[0]);
    wrap_up();
  end
endmodule
`default_nettype wire
